/* design/link_request_stream_decoder.v */
// Decoder for the serial service-request stream on the link request line.
// Assumes the request line and the controller-returned clock arrive
// asynchronously and are sampled by clock, which runs much faster.
`timescale 1ns/1ps
`include "link_req_consts.vh"

module link_request_stream_decoder
#(
  parameter [3:0] IFRESET_TYPE = `TYPE_IFRESET_DEF
)
(
  // Clock and reset.
  input  wire        clock,
  input  wire        resetn,
  // Link pins.
  input  wire        linkRequestLine,
  input  wire        controllerReturnedClock,
  // Register write towards the register file.
  output reg         regWriteStrobe,
  output reg  [3:0]  regWriteAddr,
  output reg  [7:0]  regWriteData,
  // Notifications and pulses.
  output reg         ifResetPulse,
  output reg         isoPhaseOdd,
  output reg         cycleStartDue,
  // AXI4-Lite slave.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ========================================================================
  // Decoding helpers.

  // Expected stream length for a type code, zero when the code is illegal.
  function [4:0] streamLen;
    input [3:0] code;
    begin
      if (code == IFRESET_TYPE)
        streamLen = `LEN_NOTIFY;
      else
        case (code)
          `TYPE_IMMED, `TYPE_NEXT_EVEN, `TYPE_NEXT_ODD, `TYPE_CURRENT,
          `TYPE_ISO_EVEN, `TYPE_ISO_ODD, `TYPE_CYC_START:
            streamLen = `LEN_BUS;
          `TYPE_REG_READ:  streamLen = `LEN_READ;
          `TYPE_REG_WRITE: streamLen = `LEN_WRITE;
          `TYPE_PHASE_EVEN, `TYPE_PHASE_ODD, `TYPE_CYC_DUE:
            streamLen = `LEN_NOTIFY;
          default:         streamLen = 5'd0;
        endcase
    end
  endfunction

  // Speed class: 0 valid, 1 reserved, 2 invalid.
  function [1:0] speedClass;
    input [3:0] spd;
    begin
      case (spd)
        `SPEED_S100, `SPEED_S200, `SPEED_S400, `SPEED_S800:
          speedClass = 2'd0;
        4'h1, 4'h3, 4'h5: speedClass = 2'd1;
        default:          speedClass = 2'd2;
      endcase
    end
  endfunction

  // ========================================================================
  // Two-stage synchronisers; only the second stage is read.
  reg [1:0] reqSync_ff;
  reg [1:0] clkSync_ff;
  reg       clkPrev_ff;
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      reqSync_ff <= 2'b00;
      clkSync_ff <= 2'b00;
      clkPrev_ff <= 1'b0;
    end
    else
    begin
      reqSync_ff <= {reqSync_ff[0], linkRequestLine};
      clkSync_ff <= {clkSync_ff[0], controllerReturnedClock};
      clkPrev_ff <= clkSync_ff[1];
    end
  end

  // Sample point: rising edge of the synchronised link clock.
  wire sampleEdge = clkSync_ff[1] & ~clkPrev_ff;
  wire reqBit     = reqSync_ff[1];

  // ========================================================================
  // Stream receiver state.
  localparam ST_IDLE = 1'b0;
  localparam ST_BITS = 1'b1;

  reg        state_ff;
  reg [4:0]  bitCnt_ff;      // Index of the next bit to be received.
  reg [16:0] shift_ff;       // Bits 1..17 collected MSB first.
  reg [31:0] control_ff;
  reg [7:0]  busPend_ff;     // One pending flag per bus type (0..7 = 1..8).
  reg [7:0]  busFmt_ff;
  reg [7:0]  busNull_ff;
  reg [3:0]  lastSpeed_ff;
  reg [3:0]  lastType_ff;
  reg        readPend_ff;
  reg [3:0]  readAddr_ff;
  reg        ifError_ff;
  reg        reservedSpeed_ff;
  reg        isoPhaseEven_ff;
  reg [7:0]  reqCount_ff;

  wire [16:0] nxt_shift = {shift_ff[15:0], reqBit};
  // Type code once bits 1..4 are in: at bitCnt >= 5 the code sits at
  // position bitCnt-1 down in nxt_shift; track it by a held copy instead.
  reg  [3:0]  curType_ff;
  wire [4:0]  curLen = streamLen(curType_ff);
  // Bus request may end at bit 10 when speed bit 6 (MSB of speed) is zero.
  wire        shortOk = (curLen == `LEN_BUS) && (bitCnt_ff == `LEN_BUS_SHORT)
                        && !shift_ff[3];
  wire [3:0]  busSpeed = shift_ff[3:0];
  wire        busFmt   = shift_ff[4];
  wire [2:0]  busIdx   = curType_ff[2:0] - 3'd1;

  // Software clear wins only when no set arrives in the same cycle.
  wire wrCtrl;
  wire [31:0] wrData;

  // Receiver: start detection, bit counting, decode at the last bit.
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      state_ff         <= ST_IDLE;
      bitCnt_ff        <= 5'd0;
      shift_ff         <= 17'h00000;
      curType_ff       <= 4'h0;
      busPend_ff       <= 8'h00;
      busFmt_ff        <= 8'h00;
      busNull_ff       <= 8'h00;
      lastSpeed_ff     <= 4'h0;
      lastType_ff      <= 4'h0;
      readPend_ff      <= 1'b0;
      readAddr_ff      <= 4'h0;
      ifError_ff       <= 1'b0;
      reservedSpeed_ff <= 1'b0;
      isoPhaseEven_ff  <= 1'b1;
      isoPhaseOdd      <= 1'b0;
      cycleStartDue    <= 1'b0;
      ifResetPulse     <= 1'b0;
      regWriteStrobe   <= 1'b0;
      regWriteAddr     <= 4'h0;
      regWriteData     <= 8'h00;
      reqCount_ff      <= 8'h00;
    end
    else
    begin
      regWriteStrobe <= 1'b0;
      ifResetPulse   <= 1'b0;
      // Software clears; a set later in this block overrides them.
      if (wrCtrl)
      begin
        if (wrData[`CTRL_CLR_READ])  readPend_ff <= 1'b0;
        if (wrData[`CTRL_CLR_ERROR]) ifError_ff  <= 1'b0;
        if (wrData[`CTRL_CLR_BUS])   busPend_ff  <= 8'h00;
        if (wrData[`CTRL_CLR_ERROR]) reservedSpeed_ff <= 1'b0;
        if (wrData[`CTRL_CLR_BUS])   cycleStartDue <= 1'b0;
      end
      if (sampleEdge)
      begin
        case (state_ff)
          ST_IDLE:
          begin
            // Low idle level is ignored; a high sample is a start bit.
            if (reqBit)
            begin
              state_ff  <= ST_BITS;
              bitCnt_ff <= 5'd1;
            end
          end
          ST_BITS:
          begin
            shift_ff  <= nxt_shift;
            bitCnt_ff <= bitCnt_ff + 5'd1;
            if (bitCnt_ff == 5'd4)
            begin
              curType_ff <= nxt_shift[3:0];
              if (streamLen(nxt_shift[3:0]) == 5'd0)
              begin
                ifError_ff <= 1'b1;
                state_ff   <= ST_IDLE;
              end
            end
            else if (bitCnt_ff >= 5'd5 &&
                     (bitCnt_ff == curLen - 5'd1 || shortOk))
            begin
              state_ff <= ST_IDLE;
              // A missing stop bit is illegal, except for the short form.
              if (reqBit && !shortOk)
                ifError_ff <= 1'b1;
              else
              begin
                // A high bit 10 after an omitted stop is the next start,
                // so the short request is kept and a new frame begins.
                if (reqBit)
                begin
                  state_ff  <= ST_BITS;
                  bitCnt_ff <= 5'd1;
                end
                lastType_ff <= curType_ff;
                reqCount_ff <= reqCount_ff + 8'h01;
                if (curType_ff == IFRESET_TYPE)
                  ifResetPulse <= 1'b1;
                else
                  case (curType_ff)
                    `TYPE_IMMED, `TYPE_NEXT_EVEN, `TYPE_NEXT_ODD,
                    `TYPE_CURRENT, `TYPE_ISO_EVEN, `TYPE_ISO_ODD,
                    `TYPE_CYC_START:
                    begin
                      // Newer request of a type replaces the older one.
                      busPend_ff[busIdx] <= 1'b1;
                      busFmt_ff[busIdx]  <= busFmt;
                      busNull_ff[busIdx] <=
                        (speedClass(busSpeed) == 2'd2);
                      lastSpeed_ff <= busSpeed;
                      if (speedClass(busSpeed) == 2'd1)
                        reservedSpeed_ff <= 1'b1;
                    end
                    `TYPE_REG_READ:
                    begin
                      // Further reads are ignored until answered.
                      if (!readPend_ff)
                      begin
                        readPend_ff <= 1'b1;
                        readAddr_ff <= shift_ff[3:0];
                      end
                    end
                    `TYPE_REG_WRITE:
                    begin
                      regWriteStrobe <= 1'b1;
                      regWriteAddr   <= shift_ff[11:8];
                      regWriteData   <= shift_ff[7:0];
                    end
                    `TYPE_PHASE_EVEN:
                    begin
                      isoPhaseEven_ff <= 1'b1;
                      isoPhaseOdd     <= 1'b0;
                      cycleStartDue   <= 1'b0;
                    end
                    `TYPE_PHASE_ODD:
                    begin
                      isoPhaseEven_ff <= 1'b0;
                      isoPhaseOdd     <= 1'b1;
                      cycleStartDue   <= 1'b0;
                    end
                    `TYPE_CYC_DUE: cycleStartDue <= 1'b1;
                    default: ifError_ff <= 1'b1;
                  endcase
              end
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // AXI4-Lite slave: write takes address and data in either order.
  reg        awHave_ff;
  reg        wHave_ff;
  reg [7:0]  awAddr_ff;
  reg [31:0] wData_ff;
  wire       wrFire = awHave_ff && wHave_ff && !s_axi_bvalid;
  assign wrCtrl = wrFire && (awAddr_ff == `REG_CONTROL);
  assign wrData = wData_ff;

  always @(posedge clock)
  begin
    if (!resetn)
    begin
      awHave_ff     <= 1'b0;
      wHave_ff      <= 1'b0;
      awAddr_ff     <= 8'h00;
      wData_ff      <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      control_ff    <= `CONTROL_RESET;
    end
    else
    begin
      s_axi_awready <= !awHave_ff && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !wHave_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wrFire)
      begin
        awHave_ff    <= 1'b0;
        wHave_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the control register is writable; others answer SLVERR.
        s_axi_bresp  <= (awAddr_ff == `REG_CONTROL) ? 2'b00 : 2'b10;
        if (awAddr_ff == `REG_CONTROL)
          control_ff <= wData_ff;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle after the address is taken, data is valid.
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `REG_STATUS:     s_axi_rdata <= {24'h000000, isoPhaseOdd,
                             isoPhaseEven_ff, cycleStartDue,
                             reservedSpeed_ff, ifError_ff, readPend_ff,
                             (state_ff == ST_BITS), 1'b0};
          `REG_LAST_REQ:   s_axi_rdata <= {20'h00000, readAddr_ff,
                             lastSpeed_ff, lastType_ff};
          `REG_BUS_PEND:   s_axi_rdata <= {8'h00, busNull_ff, busFmt_ff,
                             busPend_ff};
          `REG_REG_ACCESS: s_axi_rdata <= {20'h00000, regWriteAddr,
                             regWriteData};
          `REG_CONTROL:    s_axi_rdata <= control_ff;
          `REG_COUNTS:     s_axi_rdata <= {24'h000000, reqCount_ff};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // link_request_stream_decoder

/* design/link_req_consts.vh */
// Constants for the serial link request stream decoder.
// Assumes inclusion by the decoder and the bench only.
`ifndef LINK_REQ_CONSTS_VH
`define LINK_REQ_CONSTS_VH

// ==========================================================================
// AXI4-Lite register offsets (byte addresses).
`define REG_STATUS       8'h00
`define REG_LAST_REQ     8'h04
`define REG_BUS_PEND     8'h08
`define REG_REG_ACCESS   8'h0C
`define REG_CONTROL      8'h10
`define REG_COUNTS       8'h14

// ==========================================================================
// Stream lengths in bits, start and stop bits included; LEN_BUS_SHORT has no stop bit.
`define LEN_BUS          5'd11
`define LEN_BUS_SHORT    5'd10
`define LEN_READ         5'd10
`define LEN_WRITE        5'd18
`define LEN_NOTIFY       5'd6

// ==========================================================================
// Request type codes.
`define TYPE_IMMED       4'h1
`define TYPE_NEXT_EVEN   4'h2
`define TYPE_NEXT_ODD    4'h3
`define TYPE_CURRENT     4'h4
`define TYPE_ISO_EVEN    4'h6
`define TYPE_ISO_ODD     4'h7
`define TYPE_CYC_START   4'h8
`define TYPE_REG_READ    4'hA
`define TYPE_REG_WRITE   4'hB
`define TYPE_PHASE_EVEN  4'hC
`define TYPE_PHASE_ODD   4'hD
`define TYPE_CYC_DUE     4'hE
`define TYPE_IFRESET_DEF 4'hF

// ==========================================================================
// Speed codes.
`define SPEED_S100       4'h0
`define SPEED_S200       4'h2
`define SPEED_S400       4'h4
`define SPEED_S800       4'h6

// ==========================================================================
// Reset values and control field positions.
`define CONTROL_RESET    32'h0000_0000
`define CTRL_CLR_READ    0
`define CTRL_CLR_ERROR   1
`define CTRL_CLR_BUS     2

`endif

/* test/link_ctrl_model.sv */
// Model of the link controller that drives the serial request line.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps
// ==========================================================================
// Link controller model
module link_ctrl_model
(
  // Link pins.
  output reg linkRequestLine,
  output reg controllerReturnedClock
);
  // Line rests low and the clock stands still between frames.
  initial
  begin
    linkRequestLine = 1'b0;
    controllerReturnedClock = 1'b0;
  end

  // Frame is start, type, left-justified payload, optional stop bit.
  // The line moves on the falling edge so it is steady at each rise.
  task automatic send(input [3:0] ty, input [11:0] pay, input int np,
                      input int ns, input bit sv);
    logic [17:0] f;
    int          i;
    begin
      f = {1'b1, ty, pay, 1'b0};
      if (ns != 0)
        f[12 - np] = sv;
      for (i = 17; i > 12 - np - ns; i--)
      begin
        linkRequestLine = f[i];
        #62.5 controllerReturnedClock = 1'b1;
        #62.5 controllerReturnedClock = 1'b0;
      end
      linkRequestLine = 1'b0;
    end
  endtask
endmodule // link_ctrl_model

/* test/link_req_checker_sva.sv */
// Assertions on the request stream decoder ports.
// Assumes it is bound onto the decoder and sees only its ports.
`timescale 1ns/1ps
// ==========================================================================
// Checker
module link_req_checker
(
  // Clock and reset.
  input wire        clock,
  input wire        resetn,
  // Link and decoded outputs.
  input wire        controllerReturnedClock,
  input wire        regWriteStrobe,
  input wire [3:0]  regWriteAddr,
  input wire [7:0]  regWriteData,
  input wire        ifResetPulse,
  input wire        isoPhaseOdd,
  input wire        cycleStartDue,
  // Register bus read side.
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid
);
  reg [2:0] linkSync_ff;
  reg [5:0] quiet_ff;

  // Cycles since the last link clock rise; a decode result out of an
  // idle link means the decoder acted on something it never sampled.
  always @(posedge clock)
  begin
    linkSync_ff <= {linkSync_ff[1:0], controllerReturnedClock};
    if (!resetn)
      quiet_ff <= 6'h3F;
    else if (linkSync_ff[1] && !linkSync_ff[2])
      quiet_ff <= 6'h00;
    else if (quiet_ff != 6'h3F)
      quiet_ff <= quiet_ff + 6'h01;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_strobe_pulse:
    assert property (regWriteStrobe |=> !regWriteStrobe)
    else $error("Write strobe lasted more than one cycle.");
  a_strobe_link:
    assert property (regWriteStrobe |-> quiet_ff < 6'd20)
    else $error("Write strobe without a recent link frame.");
  a_addr_held:
    assert property ($changed(regWriteAddr) |-> regWriteStrobe)
    else $error("Write address moved without a write.");
  a_data_held:
    assert property ($changed(regWriteData) |-> regWriteStrobe)
    else $error("Write data moved without a write.");
  a_reset_pulse:
    assert property (ifResetPulse |-> quiet_ff < 6'd20 ##1 !ifResetPulse)
    else $error("Interface reset pulse malformed.");
  a_phase_link:
    assert property ($changed(isoPhaseOdd) |-> quiet_ff < 6'd20)
    else $error("Phase changed without a notification.");
  a_due_set:
    assert property ($rose(cycleStartDue) |-> quiet_ff < 6'd20)
    else $error("Cycle start due set without a notification.");
  a_phase_clears:
    assert property ($changed(isoPhaseOdd) |-> ##[0:2] !cycleStartDue)
    else $error("Phase notification left cycle start due set.");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer not one cycle after address.");
endmodule // link_req_checker

bind link_request_stream_decoder link_req_checker u_chk (.clock, .resetn,
  .controllerReturnedClock, .regWriteStrobe, .regWriteAddr, .regWriteData,
  .ifResetPulse, .isoPhaseOdd, .cycleStartDue, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);

/* test/tb_top.sv */
// Self-checking bench for the request stream decoder.
// Assumes the link controller model and the bound checker.
`timescale 1ns/1ps
`include "link_req_consts.vh"
// ==========================================================================
// Bench top
module tb_top;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  wire         linkRequestLine, controllerReturnedClock;
  wire         regWriteStrobe, ifResetPulse, isoPhaseOdd, cycleStartDue;
  wire  [3:0]  regWriteAddr;
  wire  [7:0]  regWriteData;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic [1:0]  resp;
  int          failures = 0;
  int          n_compared = 0;

  // 100 MHz clock.
  always #5 clock = ~clock;

  link_ctrl_model u_link (.linkRequestLine, .controllerReturnedClock);
  link_request_stream_decoder u_dut (.clock, .resetn, .linkRequestLine,
    .controllerReturnedClock, .regWriteStrobe, .regWriteAddr,
    .regWriteData, .ifResetPulse, .isoPhaseOdd, .cycleStartDue,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // ========================================================================
  // Reporting
  task automatic complete_run;
    begin
      $display("Compared %0d, mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        failures++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic timed_out;
    begin
      check(32'h0, 32'h1);
      complete_run();
    end
  endtask

  // ========================================================================
  // Register bus master; each task ends one edge after releasing ready.
  task automatic axiWrite(input [7:0] a, input [31:0] d, output [1:0] r);
    int k;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        k++;
      end
      while (s_axi_bvalid !== 1'b1 && k < 100);
      if (k == 100) timed_out();
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
    end
  endtask

  task automatic axiRead(input [7:0] a, output [31:0] d, output [1:0] r);
    int k;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clock);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        k++;
      end
      while (s_axi_rvalid !== 1'b1 && k < 100);
      if (k == 100) timed_out();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
    end
  endtask

  task automatic rdChk(input [7:0] a, input [31:0] m, input [31:0] e);
    logic [31:0] d;
    begin
      axiRead(a, d, resp);
      check(d & m, e);
    end
  endtask

  // ========================================================================
  // Link helpers: a frame then time for the decode to land.
  task automatic frame(input [3:0] ty, input [11:0] pay, input int np,
                       input int ns, input bit sv);
    begin
      u_link.send(ty, pay, np, ns, sv);
      repeat (10) @(posedge clock);
    end
  endtask

  // Pulses last one cycle, so the watch runs beside the frame.
  task automatic sendWait(input [3:0] ty, input [11:0] pay, input int np,
                          input bit rst);
    int k;
    begin
      k = 0;
      fork
        u_link.send(ty, pay, np, 1, 1'b0);
        while (k < 400 && (rst ? ifResetPulse : regWriteStrobe) !== 1'b1)
        begin
          @(posedge clock);
          k++;
        end
      join
      if (k == 400) timed_out();
    end
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_write;
    logic [11:0] w [2] = '{12'hC35, 12'h3CA};
    int          i;
    begin
      for (i = 0; i < 2; i++)
      begin
        sendWait(`TYPE_REG_WRITE, w[i], 12, 1'b0);
        check({regWriteAddr, regWriteData}, w[i]);
      end
      $display("t_write done");
    end
  endtask

  task automatic t_bus;
    logic [3:0] ty [9] = '{1, 2, 3, 4, 6, 7, 8, 1, 2};
    logic [4:0] fs [9] = '{5'h10, 5'h02, 5'h14, 5'h06, 5'h10, 5'h02,
                           5'h14, 5'h09, 5'h13};
    int         st [9] = '{1, 1, 0, 1, 1, 1, 0, 1, 1};
    int         i;
    begin
      for (i = 0; i < 9; i++)
        u_link.send(ty[i], {fs[i], 7'h00}, 5, st[i], 1'b0);
      repeat (10) @(posedge clock);
      rdChk(`REG_BUS_PEND, 32'hFFFFFF, 32'h01A6EF);
      rdChk(`REG_STATUS, 32'h10, 32'h10);
      axiWrite(`REG_CONTROL, 32'h4, resp);
      check(resp, 2'b00);
      rdChk(`REG_BUS_PEND, 32'hFF, 32'h00);
      $display("t_bus done");
    end
  endtask

  task automatic t_notify;
    begin
      frame(`TYPE_PHASE_ODD, 12'h000, 0, 1, 1'b0);
      check(isoPhaseOdd, 1'b1);
      frame(`TYPE_CYC_DUE, 12'h000, 0, 1, 1'b0);
      check(cycleStartDue, 1'b1);
      frame(`TYPE_PHASE_EVEN, 12'h000, 0, 1, 1'b0);
      check({isoPhaseOdd, cycleStartDue}, 2'b00);
      $display("t_notify done");
    end
  endtask

  task automatic t_read;
    begin
      frame(`TYPE_REG_READ, 12'h500, 4, 1, 1'b0);
      frame(`TYPE_REG_READ, 12'h900, 4, 1, 1'b0);
      rdChk(`REG_LAST_REQ, 32'hF00, 32'h500);
      rdChk(`REG_STATUS, 32'h04, 32'h04);
      axiWrite(`REG_CONTROL, 32'h1, resp);
      rdChk(`REG_STATUS, 32'h04, 32'h00);
      $display("t_read done");
    end
  endtask

  task automatic t_illegal;
    logic [3:0] bad [3] = '{4'h0, 4'h5, 4'h9};
    int         i;
    logic [31:0] d;
    begin
      for (i = 0; i < 3; i++)
      begin
        frame(bad[i], 12'h000, 0, 0, 1'b0);
        rdChk(`REG_STATUS, 32'h08, 32'h08);
        axiWrite(`REG_CONTROL, 32'h2, resp);
        rdChk(`REG_STATUS, 32'h08, 32'h00);
      end
      sendWait(`TYPE_IFRESET_DEF, 12'h000, 0, 1'b1);
      frame(`TYPE_CYC_DUE, 12'h000, 0, 1, 1'b1);
      rdChk(`REG_STATUS, 32'h08, 32'h08);
      axiRead(8'h18, d, resp);
      check(d, 32'h0);
      check(resp, 2'b10);
      axiWrite(`REG_STATUS, 32'hFF, resp);
      check(resp, 2'b10);
      $display("t_illegal done");
    end
  endtask

  // ========================================================================
  // Main sequence: five cycles of reset, then each scenario in turn.
  initial
  begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_write();
    t_bus();
    t_notify();
    t_read();
    t_illegal();
    complete_run();
  end
endmodule // tb_top
